//--- src/pthcc_consts.svh
// constants for the humidity configuration and compensation block
`ifndef PTHCC_CONSTS_SVH
`define PTHCC_CONSTS_SVH
`define PTHCC_CMD_WRITE_CFG 8'hE6
`define PTHCC_CMD_READ_CFG  8'hE7
`define PTHCC_CFG_RESET     8'h00
`define PTHCC_BIT_RES_HI    7
`define PTHCC_BIT_SUPPLY    6
`define PTHCC_BIT_HEATER    2
`define PTHCC_BIT_RES_LO    0
`define PTHCC_RSVD_MASK     8'h3A
`define PTHCC_WRITE_MASK    8'h85
`define PTHCC_HUM_MIN       16'h0000
`define PTHCC_HUM_MAX       16'hFFFF
`define PTHCC_TEMP_BASE     2000
`define PTHCC_TREF_SHIFT    8
`define PTHCC_TEMP_SHIFT    23
`define PTHCC_OFF_SHIFT_HI  17
`define PTHCC_OFF_SHIFT_LO  6
`define PTHCC_GAIN_SHIFT_HI 16
`define PTHCC_GAIN_SHIFT_LO 7
`define PTHCC_P_SHIFT_A     21
`define PTHCC_P_SHIFT_B     15
`endif

//--- src/pthcc_pkg.sv
// types for the humidity configuration and compensation block
package pthcc_pkg;
	typedef enum logic [3:0] {
		PTHCC_IDLE  = 4'h1,
		PTHCC_DELTA = 4'h2,
		PTHCC_TERMS = 4'h4,
		PTHCC_OUT   = 4'h8
	} pthcc_state_e;
	typedef struct packed {
		pthcc_state_e     state;
		logic signed [31:0] delta;
		logic signed [63:0] shift;
		logic signed [63:0] gain;
		logic signed [31:0] temp;
		logic signed [31:0] pres;
		logic             done;
	} pthcc_comp_s;
	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  rdData;
		logic        rdValid;
		logic [15:0] humWord;
		logic        humValid;
		logic [1:0]  resSel;
		logic        heaterOn;
	} pthcc_top_s;
endpackage

//--- src/pthcc_compensate.sv
// first-order fixed-point pressure and temperature compensation
`timescale 1ns/1ns
`default_nettype none
`include "pthcc_consts.svh"
module pthcc_compensate (
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               start,
	input  wire logic [15:0]        gainCoefficient,
	input  wire logic [15:0]        zeroShiftCoefficient,
	input  wire logic [15:0]        gainTempco,
	input  wire logic [15:0]        zeroShiftTempco,
	input  wire logic [15:0]        referenceThermalCode,
	input  wire logic [15:0]        thermalSlope,
	input  wire logic [23:0]        rawPressure,
	input  wire logic [23:0]        rawThermal,
	output logic signed [31:0]      temperature,
	output logic signed [31:0]      pressure,
	output logic                    done
);
	pthcc_pkg::pthcc_comp_s st_r;
	pthcc_pkg::pthcc_comp_s st_nxt;
	logic signed [63:0] d64;
	logic signed [63:0] tProd;
	logic signed [63:0] pProd;
	assign d64 = 64'(st_r.delta);
	// coefficients enter as zero-extended unsigned words (see R6)
	assign tProd = d64 * $signed({48'h0, thermalSlope});
	// raw readings arrive as 24-bit unsigned words
	assign pProd = $signed({40'h0, rawPressure}) * st_r.gain; // see R19
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		unique case (st_r.state)
			pthcc_pkg::PTHCC_IDLE: begin
				if (start) begin
					st_nxt.state = pthcc_pkg::PTHCC_DELTA;
				end
			end
			pthcc_pkg::PTHCC_DELTA: begin
				st_nxt.delta = $signed({8'h0, rawThermal})
					- $signed({8'h0, referenceThermalCode, 8'h00}); // see R7
				st_nxt.state = pthcc_pkg::PTHCC_TERMS;
			end
			pthcc_pkg::PTHCC_TERMS: begin
				// shifts on signed operands are arithmetic (see R20)
				st_nxt.temp = 32'(`PTHCC_TEMP_BASE + (tProd >>> `PTHCC_TEMP_SHIFT)); // see R8
				st_nxt.shift = ($signed({48'h0, zeroShiftCoefficient}) <<< `PTHCC_OFF_SHIFT_HI)
					+ (($signed({48'h0, zeroShiftTempco}) * d64) >>> `PTHCC_OFF_SHIFT_LO); // see R9
				st_nxt.gain = ($signed({48'h0, gainCoefficient}) <<< `PTHCC_GAIN_SHIFT_HI)
					+ (($signed({48'h0, gainTempco}) * d64) >>> `PTHCC_GAIN_SHIFT_LO); // see R10
				st_nxt.state = pthcc_pkg::PTHCC_OUT;
			end
			pthcc_pkg::PTHCC_OUT: begin
				st_nxt.pres = 32'(((pProd >>> `PTHCC_P_SHIFT_A) - st_r.shift)
					>>> `PTHCC_P_SHIFT_B); // see R11
				st_nxt.done = 1'b1;
				st_nxt.state = pthcc_pkg::PTHCC_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{state: pthcc_pkg::PTHCC_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign temperature = st_r.temp;
	assign pressure = st_r.pres;
	assign done = st_r.done;
endmodule
`default_nettype wire

//--- src/pthcc_top.sv
// humidity configuration register, humidity clamp and compensation wrapper
// Summary of operation
// R1: resolution from bits 7 and 0, default 00
// R2: bit 6 shows supply low, read only
// R3: bits 1,3,4,5 reserved, reset to zero
// R4: host reads before write, keeps reserved bits
// R5: bit 2 enables heater, default off
// R6: six calibration words are 16-bit unsigned
// R7: delta is raw thermal minus reference shifted
// R8: temperature is 2000 plus scaled delta product
// R9: zero shift from coefficient and tempco term
// R10: gain from coefficient and tempco term
// R11: pressure from raw pressure, gain, shift
// R12: second-order corrections optional, not built
// R13: host converts humidity word to percent
// R14: humidity word clamps at maximum code
// R15: humidity word clamps at minimum code
// R16: humidity delivered as full 16-bit word
// R17: command E6 writes configuration byte
// R18: command E7 returns configuration byte
// R19: raw pressure and thermal are 24 bits
// R20: divisions are arithmetic shifts, wide products
`timescale 1ns/1ns
`default_nettype none
`include "pthcc_consts.svh"
module pthcc_top (
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               cmdValid,
	input  wire logic [7:0]         cmdCode,
	input  wire logic [7:0]         cmdData,
	input  wire logic               supplyLow,
	input  wire logic               humSample,
	input  wire logic signed [17:0] humLevel,
	input  wire logic               compStart,
	input  wire logic [15:0]        gainCoefficient,
	input  wire logic [15:0]        zeroShiftCoefficient,
	input  wire logic [15:0]        gainTempco,
	input  wire logic [15:0]        zeroShiftTempco,
	input  wire logic [15:0]        referenceThermalCode,
	input  wire logic [15:0]        thermalSlope,
	input  wire logic [23:0]        rawPressure,
	input  wire logic [23:0]        rawThermal,
	output logic [7:0]              cfgReadData,
	output logic                    cfgReadValid,
	output logic [15:0]             humidityWord,
	output logic                    humidityValid,
	output logic [1:0]              oversamplingRatio,
	output logic                    heaterEnable,
	output logic signed [31:0]      temperature,
	output logic signed [31:0]      pressure,
	output logic                    compDone
);
	pthcc_pkg::pthcc_top_s st_r;
	pthcc_pkg::pthcc_top_s st_nxt;
	logic [7:0] liveCfg;
	always_comb begin
		liveCfg = st_r.cfg;
		liveCfg[`PTHCC_BIT_SUPPLY] = supplyLow; // see R2
	end
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdValid = 1'b0;
		st_nxt.humValid = 1'b0;
		st_nxt.cfg[`PTHCC_BIT_SUPPLY] = 1'b0;
		if (cmdValid && cmdCode == `PTHCC_CMD_WRITE_CFG) begin
			// only resolution and heater take the write; reserved bits hold (see R4, R3, R17)
			st_nxt.cfg = (st_r.cfg & ~`PTHCC_WRITE_MASK) | (cmdData & `PTHCC_WRITE_MASK);
			st_nxt.cfg[`PTHCC_BIT_SUPPLY] = 1'b0;
		end
		if (cmdValid && cmdCode == `PTHCC_CMD_READ_CFG) begin
			st_nxt.rdData = liveCfg; // see R18
			st_nxt.rdValid = 1'b1;
		end
		st_nxt.resSel = {st_nxt.cfg[`PTHCC_BIT_RES_HI], st_nxt.cfg[`PTHCC_BIT_RES_LO]}; // see R1
		st_nxt.heaterOn = st_nxt.cfg[`PTHCC_BIT_HEATER]; // see R5
		if (humSample) begin
			// full 16-bit word, clamped at both ends (see R16)
			if (humLevel > 18'sh0FFFF) begin
				st_nxt.humWord = `PTHCC_HUM_MAX; // see R14
			end else if (humLevel < 18'sh00000) begin
				st_nxt.humWord = `PTHCC_HUM_MIN; // see R15
			end else begin
				st_nxt.humWord = humLevel[15:0];
			end
			st_nxt.humValid = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign cfgReadData = st_r.rdData;
	assign cfgReadValid = st_r.rdValid;
	assign humidityWord = st_r.humWord;
	assign humidityValid = st_r.humValid;
	assign oversamplingRatio = st_r.resSel;
	assign heaterEnable = st_r.heaterOn;
	pthcc_compensate u_comp (
		.clk                  (clk),
		.rst_b                (rst_b),
		.start                (compStart),
		.gainCoefficient      (gainCoefficient),
		.zeroShiftCoefficient (zeroShiftCoefficient),
		.gainTempco           (gainTempco),
		.zeroShiftTempco      (zeroShiftTempco),
		.referenceThermalCode (referenceThermalCode),
		.thermalSlope         (thermalSlope),
		.rawPressure          (rawPressure),
		.rawThermal           (rawThermal),
		.temperature          (temperature),
		.pressure             (pressure),
		.done                 (compDone)
	);
endmodule
`default_nettype wire

//--- test/pthcc_host.sv
// host side model: read-modify-write of the configuration byte
`timescale 1ns/1ns
`default_nettype none
module pthcc_host (
	input  wire logic [7:0]    rdByte,
	input  wire logic [7:0]    want,
	input  wire logic [15:0]   humWord,
	output logic [7:0]         wrByte,
	output logic signed [31:0] rhCenti
);
	// reserved bits go back as read, only resolution and heater change
	assign wrByte = (rdByte & 8'h7A) | (want & 8'h85);
	// percent humidity in hundredths, same formula at every resolution
	assign rhCenti = $signed(32'(({16'h0, humWord} * 32'd12500) >> 16)) - 32'sd600;
endmodule
`default_nettype wire

//--- test/pthcc_top_sva.sv
// assertion checker for the configuration and compensation block
`timescale 1ns/1ns
`default_nettype none
module pthcc_top_sva (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       cmdValid,
	input wire logic [7:0] cmdCode,
	input wire logic [7:0] cmdData,
	input wire logic       supplyLow,
	input wire logic       humSample,
	input wire logic       compStart,
	input wire logic [7:0] cfgReadData,
	input wire logic       cfgReadValid,
	input wire logic       humidityValid,
	input wire logic [1:0] oversamplingRatio,
	input wire logic       heaterEnable,
	input wire logic       compDone
);
	logic [1:0] cnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// cycles left in a running compensation
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b) cnt_r <= 2'h0;
		else if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
		else if (compStart) cnt_r <= 2'h3;
	AST_READ: assert property (cfgReadValid == $past(cmdValid && cmdCode == 8'hE7))
		else $error("read pulse");
	AST_RSV: assert property (cfgReadValid |->
		(cfgReadData & 8'h7A) == {1'h0, $past(supplyLow), 6'h00}) else $error("fixed bits");
	AST_CFG: assert property (cfgReadValid |->
		{cfgReadData[7], cfgReadData[0], cfgReadData[2]} == $past({oversamplingRatio, heaterEnable}))
		else $error("cfg bits");
	AST_WR: assert property (cmdValid && cmdCode == 8'hE6 |=>
		{oversamplingRatio, heaterEnable} == $past({cmdData[7], cmdData[0], cmdData[2]}))
		else $error("write");
	AST_HOLD: assert property (!(cmdValid && cmdCode == 8'hE6) |=>
		$stable({oversamplingRatio, heaterEnable})) else $error("held");
	AST_HUM: assert property (humidityValid == $past(humSample)) else $error("hum");
	AST_DONE: assert property (compDone == ($past(cnt_r) == 2'h1)) else $error("done");
	AST_RUN: assert property (compStart && cnt_r == 2'h0 |-> ##4 compDone) else $error("run");
endmodule
bind pthcc_top pthcc_top_sva i_pthcc_top_sva (
	.clk               (clk),
	.rst_b             (rst_b),
	.cmdValid          (cmdValid),
	.cmdCode           (cmdCode),
	.cmdData           (cmdData),
	.supplyLow         (supplyLow),
	.humSample         (humSample),
	.compStart         (compStart),
	.cfgReadData       (cfgReadData),
	.cfgReadValid      (cfgReadValid),
	.humidityValid     (humidityValid),
	.oversamplingRatio (oversamplingRatio),
	.heaterEnable      (heaterEnable),
	.compDone          (compDone)
);
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the configuration and compensation block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic               clk = 1'h0, rst_b = 1'h0, cmdValid = 1'h0, supplyLow = 1'h0;
	logic               humSample = 1'h0, compStart = 1'h0, cfgReadValid, humidityValid;
	logic               heaterEnable, compDone;
	logic [1:0]         oversamplingRatio;
	logic [7:0]         cmdCode = '0, cmdData = '0, cfgReadData, cfgM = '0, want = '0, wrByte;
	logic [15:0]        gainCoefficient = '0, zeroShiftCoefficient = '0, gainTempco = '0;
	logic [15:0]        zeroShiftTempco = '0, referenceThermalCode = '0, thermalSlope = '0;
	logic [15:0]        humidityWord;
	logic [23:0]        rawPressure = '0, rawThermal = '0;
	logic signed [17:0] humLevel = '0, v;
	logic signed [17:0] hv[6] = '{-18'sd1, 18'sd0, 18'sd65535, 18'sd65536, 18'sd131071, -18'sd131072};
	logic signed [31:0] temperature, pressure, rhCenti;
	logic [63:0]        q[$];
	logic [63:0]        e;
	int                 err_total = 0, n_compared = 0;
	pthcc_top i_pthcc_top (
		.clk                  (clk),
		.rst_b                (rst_b),
		.cmdValid             (cmdValid),
		.cmdCode              (cmdCode),
		.cmdData              (cmdData),
		.supplyLow            (supplyLow),
		.humSample            (humSample),
		.humLevel             (humLevel),
		.compStart            (compStart),
		.gainCoefficient      (gainCoefficient),
		.zeroShiftCoefficient (zeroShiftCoefficient),
		.gainTempco           (gainTempco),
		.zeroShiftTempco      (zeroShiftTempco),
		.referenceThermalCode (referenceThermalCode),
		.thermalSlope         (thermalSlope),
		.rawPressure          (rawPressure),
		.rawThermal           (rawThermal),
		.cfgReadData          (cfgReadData),
		.cfgReadValid         (cfgReadValid),
		.humidityWord         (humidityWord),
		.humidityValid        (humidityValid),
		.oversamplingRatio    (oversamplingRatio),
		.heaterEnable         (heaterEnable),
		.temperature          (temperature),
		.pressure             (pressure),
		.compDone             (compDone)
	);
	pthcc_host i_pthcc_host (
		.rdByte  (cfgReadData),
		.want    (want),
		.humWord (humidityWord),
		.wrByte  (wrByte),
		.rhCenti (rhCenti)
	);
	always #4 clk = ~clk;
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c, d);
		logic s;
		s = 1'($urandom);
		@(posedge clk);
		cmdValid <= 1'h1;
		cmdCode <= c;
		cmdData <= d;
		supplyLow <= s;
		if (c == 8'hE6) cfgM = d & 8'h85;
		if (c == 8'hE7) q.push_back({56'h0, cfgM | {1'h0, s, 6'h00}});
		@(posedge clk);
		cmdValid <= 1'h0;
	endtask
	function automatic logic [63:0] expc();
		longint d, o, s, p, t;
		// calibration words widen as unsigned values
		d = longint'(rawThermal) - (longint'(referenceThermalCode) << 8);
		t = 2000 + ((d * longint'(thermalSlope)) >>> 23);
		o = (longint'(zeroShiftCoefficient) << 17) + ((longint'(zeroShiftTempco) * d) >>> 6);
		s = (longint'(gainCoefficient) << 16) + ((longint'(gainTempco) * d) >>> 7);
		// first order only: the optional low-temperature correction is left out
		p = (((longint'(rawPressure) * s) >>> 21) - o) >>> 15;
		return {t[31:0], p[31:0]};
	endfunction
	always @(negedge clk) begin
		if (cfgReadValid) chk("cfg", 64'(cfgReadData), q.pop_front());
		if (humidityValid) begin
			e = q.pop_front();
			chk("hum", 64'(humidityWord), e);
			chk("rh", 64'(longint'(rhCenti)), 64'(((longint'(e[15:0]) * 12500) >>> 16) - 600));
		end
		if (compDone) chk("comp", {temperature, pressure}, q.pop_front());
	end
	initial begin
		void'($urandom(43844));
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			want = {i[1], 6'($urandom), i[0]};
			cmd(8'hE7, 8'h00);
			@(negedge clk);
			cmd(8'hE6, wrByte);
			// codes E0 to E7: ignored ones, a direct write with random data and a read
			cmd(8'hE0 + 8'(i), 8'($urandom));
			cmd(8'hE7, 8'h00);
		end
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			v = k < 6 ? hv[k] : 18'($urandom);
			humSample <= 1'h1;
			humLevel <= v;
			q.push_back(v < 0 ? 64'h0 : v > 65535 ? 64'hFFFF : {48'h0, v[15:0]});
		end
		@(posedge clk);
		humSample <= 1'h0;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			{gainCoefficient, zeroShiftCoefficient, gainTempco, zeroShiftTempco} <= {$urandom, $urandom};
			{referenceThermalCode, thermalSlope} <= $urandom;
			{rawPressure, rawThermal} <= 48'({$urandom, $urandom});
			compStart <= 1'h1;
			@(posedge clk);
			q.push_back(expc());
			// a second start while busy must be ignored
			@(posedge clk);
			compStart <= 1'h0;
			repeat (3) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		chk("left", 64'(q.size()), 64'h0);
		give_verdict();
	end
	initial begin
		#20000;
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
